/* File: verilog/shs_consts.vh */
`ifndef SHS_CONSTS_VH
`define SHS_CONSTS_VH
// ****************************************************************
// register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define SHS_ADDR_APPROACH 8'h00
`define SHS_ADDR_DEPART 8'h04
`define SHS_ADDR_OFS_HIGH 8'h08
`define SHS_ADDR_OFS_LOW 8'h0c
`define SHS_ADDR_STATUS 8'h10
`define SHS_ADDR_INT_STAT 8'h14
`define SHS_ADDR_INT_MASK 8'h18
// ****************************************************************
// reset values and limits
// ****************************************************************
`define SHS_APPROACH_RST 12'h5dc
`define SHS_APPROACH_MAX 12'hbb8
`define SHS_DEPART_RST 12'h01e
`define SHS_DEPART_MAX 12'h0c8
`define SHS_OFS_RST 14'h0000
`define SHS_OFS_MAX 14'h270f
`define SHS_OFS_HIGH_WEIGHT 27'h0002710
// ****************************************************************
// field positions of the mode setting strap
// ****************************************************************
`define SHS_MODE_DIR 0
`define SHS_MODE_STYLE 1
`define SHS_MODE_EN 2
// ****************************************************************
// interrupt status bits
// ****************************************************************
`define SHS_INT_START 0
`define SHS_INT_ORIGIN 1
`define SHS_INT_INDEX 2
`define SHS_INT_DONE 3
`define SHS_INT_REFUSED 4
`define SHS_INT_W 5
// ****************************************************************
// timing counts
// ****************************************************************
`define SHS_CFG_SETTLE 2'h3
`endif

/* File: verilog/shs_sync.v */
`timescale 1ns/100ps
// ****************************************************************
// two flip-flop synchroniser for a bundle of pins
// ****************************************************************
module shs_sync #(
  parameter W = 1
) (
  input wire clk, // system clock
  input wire rst, // async reset, active high
  input wire [W-1:0] pin, // asynchronous pins
  output reg [W-1:0] q // synchronised levels
);
  reg [W-1:0] meta;

  // first stage is read only by the second stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= pin;
      q <= meta;
    end
  end
endmodule // shs_sync

/* File: verilog/shs_offset_counter.v */
`timescale 1ns/100ps
`include "shs_consts.vh"
// ****************************************************************
// offset pulse counter with weighted target
// ****************************************************************
module shs_offset_counter (
  input wire clk, // system clock
  input wire rst, // async reset, active high
  input wire clear, // restart count from zero
  input wire step, // one encoder pulse
  input wire [13:0] ofs_high, // offset in units of 10000 pulses
  input wire [13:0] ofs_low, // offset in single pulses
  output wire reached // count has reached the target
);
  reg [26:0] count;
  wire [53:0] high_prod;
  wire [26:0] target;

  // weighted sum of the two fields
  assign high_prod = {27'h0000000, 13'h0000, ofs_high} * {27'h0000000, `SHS_OFS_HIGH_WEIGHT};
  assign target = high_prod[26:0] + {13'h0000, ofs_low};
  assign reached = (count >= target);

  // counts up, stops at the target
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 27'h0000000;
    end else if (clear) begin
      count <= 27'h0000000;
    end else if (step && !reached) begin
      count <= count + 27'h0000001;
    end
  end
endmodule // shs_offset_counter

/* File: verilog/shs_homing.v */
`timescale 1ns/100ps
`include "shs_consts.vh"
// Summary of operation
// - mode direction bit 0 homes forward, 1 homes reverse.
// - style bit 0 turns back for index, 1 seeks index directly.
// - enable bit 0 disables homing, 1 arms it for start rising edge.
// - homing starts only while positioning complete is asserted.
// - host reference pulses are blocked while homing runs.
// - homing does not start while control mode is being switched.
// - control mode switch requests are refused while homing runs.
// - mode settings and pin allocations are latched at reset release.
// - approach speed 0 to 3000 rpm, default 1500, applies at once.
// - departure speed 0 to 200 rpm, default 30, applies at once.
// - offset equals high field times 10000 plus low field.
// - a rising edge of homing start begins the approach; levels do not, except one held through reset on start pin 1 to 3 while pin 0 is low.
// - valid high origin input switches to departure speed.
// - return style reverses after origin; direct style keeps direction.
// - offset counting starts at first index after leaving origin.
// - at target count motor stops and homing complete is raised.
module shs_homing (
  input wire clk, // system clock, 25 MHz
  input wire rst, // async reset, active high
  input wire [7:0] addr, // register byte address
  input wire [31:0] wdata, // register write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  output reg [31:0] rdata, // read data, cycle after rd
  input wire [2:0] homing_mode_setting, // strap: enable, style, direction
  input wire [1:0] input_pin_allocation_a, // strap: pin for homing start
  input wire [1:0] input_pin_allocation_b, // strap: pin for origin switch
  input wire [1:0] output_pin_allocation, // strap: pin for homing complete
  input wire [3:0] in_pins, // general input pins
  output reg [3:0] out_pins_n, // general output pins, active low
  input wire positioning_complete, // pin, high when in position
  input wire mode_switching, // pin, high while control mode switches
  input wire mode_switch_req, // pin, host asks for mode switch
  output wire mode_switch_grant, // mode switch allowed
  input wire ref_pulse_in, // pin, host reference pulse
  output wire ref_pulse_out, // reference pulse to position loop
  input wire index_pulse_in, // pin, encoder index pulse
  input wire encoder_step_in, // pin, encoder step, one per pulse
  output reg motor_run, // motor commanded to move
  output reg motor_reverse, // 1 = reverse direction
  output reg [11:0] speed_cmd, // commanded speed in rpm
  output reg homing_busy, // homing in progress
  output reg homing_done, // homing complete, active high
  output wire irq // interrupt, active high level
);
  // ****************************************************************
  // states
  // ****************************************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_APPROACH = 5'h02;
  localparam [4:0] ST_LEAVE = 5'h04;
  localparam [4:0] ST_COUNT = 5'h08;
  localparam [4:0] ST_STOP = 5'h10;

  reg [4:0] state;
  reg [4:0] next_state;
  reg [11:0] approach_speed;
  reg [11:0] departure_speed;
  reg [13:0] offset_count_high;
  reg [13:0] offset_count_low;
  reg [`SHS_INT_W-1:0] int_stat;
  reg [`SHS_INT_W-1:0] int_mask;
  reg [2:0] mode_lat;
  reg [1:0] alloc_start;
  reg [1:0] alloc_origin;
  reg [1:0] alloc_out;
  reg [1:0] cfg_cnt;
  reg cfg_ready;
  reg start_prev;
  reg step_prev;
  reg index_prev;
  wire [18:0] sync_q;
  wire [3:0] pins_s;
  wire poscomp_s;
  wire switching_s;
  wire swreq_s;
  wire ref_s;
  wire index_s;
  wire step_s;
  wire [2:0] mode_s;
  wire homing_start_in;
  wire origin_switch_in;
  wire start_edge;
  wire step_edge;
  wire index_edge;
  wire start_ok;
  wire cnt_clear;
  wire cnt_reached;
  wire [`SHS_INT_W-1:0] int_set;
  wire [11:0] wr_speed;
  wire [13:0] wr_ofs;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // straps share the synchroniser so capture never sees a metastable level
  shs_sync #(
    .W(19)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin({output_pin_allocation, input_pin_allocation_b, input_pin_allocation_a,
          homing_mode_setting, in_pins, positioning_complete, mode_switching,
          mode_switch_req, ref_pulse_in, index_pulse_in, encoder_step_in}),
    .q(sync_q)
  );

  assign mode_s = sync_q[12:10];
  assign pins_s = sync_q[9:6];
  assign poscomp_s = sync_q[5];
  assign switching_s = sync_q[4];
  assign swreq_s = sync_q[3];
  assign ref_s = sync_q[2];
  assign index_s = sync_q[1];
  assign step_s = sync_q[0];

  // ****************************************************************
  // configuration capture after reset release
  // ****************************************************************
  // straps are sampled once the synchronisers have filled
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_cnt <= 2'h0;
      cfg_ready <= 1'b0;
      mode_lat <= 3'h0;
      alloc_start <= 2'h0;
      alloc_origin <= 2'h0;
      alloc_out <= 2'h0;
    end else if (!cfg_ready) begin
      cfg_cnt <= cfg_cnt + 2'h1;
      if (cfg_cnt == `SHS_CFG_SETTLE) begin
        cfg_ready <= 1'b1;
        mode_lat <= mode_s;
        alloc_start <= sync_q[14:13];
        alloc_origin <= sync_q[16:15];
        alloc_out <= sync_q[18:17];
      end
    end
  end

  // routed inputs from the latched allocation
  assign homing_start_in = pins_s[alloc_start];
  assign origin_switch_in = pins_s[alloc_origin];

  // ****************************************************************
  // edge detection
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      start_prev <= 1'b1;
      step_prev <= 1'b0;
      index_prev <= 1'b0;
    end else begin
      start_prev <= homing_start_in;
      step_prev <= step_s;
      index_prev <= index_s;
    end
  end

  // a start level held through reset on pin 0 gives its edge before cfg_ready is set; on pins 1 to 3 the edge can come with cfg_ready
  assign start_edge = homing_start_in & ~start_prev;
  assign step_edge = step_s & ~step_prev;
  assign index_edge = index_s & ~index_prev;

  // start accepted only when armed, in position, not switching
  assign start_ok = cfg_ready && mode_lat[`SHS_MODE_EN] && start_edge
                    && poscomp_s
                    && !switching_s;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_APPROACH;
        end
      end
      ST_APPROACH: begin
        if (origin_switch_in) begin
          next_state = ST_LEAVE;
        end
      end
      ST_LEAVE: begin
        if (index_edge && !origin_switch_in) begin
          next_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (cnt_reached) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // offset counter restarts at the first index after leaving origin
  assign cnt_clear = (state != ST_COUNT);

  shs_offset_counter u_cnt (
    .clk(clk),
    .rst(rst),
    .clear(cnt_clear),
    .step(step_edge),
    .ofs_high(offset_count_high),
    .ofs_low(offset_count_low),
    .reached(cnt_reached)
  );

  // ****************************************************************
  // motor command and completion flag
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      motor_run <= 1'b0;
      motor_reverse <= 1'b0;
      speed_cmd <= 12'h000;
      homing_busy <= 1'b0;
      homing_done <= 1'b0;
    end else begin
      case (next_state)
        ST_APPROACH: begin
          motor_run <= 1'b1;
          motor_reverse <= mode_lat[`SHS_MODE_DIR];
          speed_cmd <= approach_speed;
          homing_busy <= 1'b1;
          homing_done <= 1'b0;
        end
        ST_LEAVE, ST_COUNT: begin
          motor_run <= 1'b1;
          // return style turns back, direct style keeps going
          motor_reverse <= mode_lat[`SHS_MODE_STYLE] ? mode_lat[`SHS_MODE_DIR]
                                                     : ~mode_lat[`SHS_MODE_DIR];
          speed_cmd <= departure_speed;
          homing_busy <= 1'b1;
        end
        ST_STOP: begin
          motor_run <= 1'b0;
          speed_cmd <= 12'h000;
          homing_busy <= 1'b0;
          homing_done <= 1'b1;
        end
        default: begin
          motor_run <= 1'b0;
          speed_cmd <= 12'h000;
          homing_busy <= 1'b0;
        end
      endcase
    end
  end

  // homing complete drives its allocated pin low
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      out_pins_n <= 4'hf;
    end else begin
      out_pins_n <= 4'hf;
      out_pins_n[alloc_out] <= ~homing_done;
    end
  end

  // host pulses and mode switches are locked out while busy
  assign ref_pulse_out = ref_s & ~homing_busy;
  assign mode_switch_grant = swreq_s & ~homing_busy;

  // ****************************************************************
  // register writes
  // ****************************************************************
  // out of range writes clamp to the upper limit
  assign wr_speed = wdata[11:0];
  assign wr_ofs = (wdata[13:0] > `SHS_OFS_MAX) ? `SHS_OFS_MAX : wdata[13:0];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      approach_speed <= `SHS_APPROACH_RST;
      departure_speed <= `SHS_DEPART_RST;
      offset_count_high <= `SHS_OFS_RST;
      offset_count_low <= `SHS_OFS_RST;
      int_mask <= {`SHS_INT_W{1'b0}};
    end else if (wr) begin
      case (addr)
        `SHS_ADDR_APPROACH: approach_speed <= (wdata[31:12] != 20'h00000
          || wr_speed > `SHS_APPROACH_MAX) ? `SHS_APPROACH_MAX : wr_speed;
        `SHS_ADDR_DEPART: departure_speed <= (wdata[31:12] != 20'h00000
          || wr_speed > `SHS_DEPART_MAX) ? `SHS_DEPART_MAX : wr_speed;
        `SHS_ADDR_OFS_HIGH: begin
          offset_count_high <= (wdata[31:14] != 18'h00000) ? `SHS_OFS_MAX : wr_ofs;
        end
        `SHS_ADDR_OFS_LOW: begin
          offset_count_low <= (wdata[31:14] != 18'h00000) ? `SHS_OFS_MAX : wr_ofs;
        end
        `SHS_ADDR_INT_MASK: int_mask <= wdata[`SHS_INT_W-1:0];
        default: int_mask <= int_mask;
      endcase
    end
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  assign int_set[`SHS_INT_START] = start_ok && (state == ST_IDLE);
  assign int_set[`SHS_INT_ORIGIN] = (state == ST_APPROACH) && (next_state == ST_LEAVE);
  assign int_set[`SHS_INT_INDEX] = (state == ST_LEAVE) && (next_state == ST_COUNT);
  assign int_set[`SHS_INT_DONE] = (state == ST_STOP);
  assign int_set[`SHS_INT_REFUSED] = (start_edge && cfg_ready && mode_lat[`SHS_MODE_EN]
                                      && (!poscomp_s || switching_s))
                                     || (swreq_s && homing_busy);

  // write one to clear, a new event in the same cycle wins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      int_stat <= {`SHS_INT_W{1'b0}};
    end else begin
      if (wr && addr == `SHS_ADDR_INT_STAT) begin
        int_stat <= (int_stat & ~wdata[`SHS_INT_W-1:0]) | int_set;
      end else begin
        int_stat <= int_stat | int_set;
      end
    end
  end

  assign irq = |(int_stat & int_mask);

  // ****************************************************************
  // register reads
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `SHS_ADDR_APPROACH: rdata <= {20'h00000, approach_speed};
        `SHS_ADDR_DEPART: rdata <= {20'h00000, departure_speed};
        `SHS_ADDR_OFS_HIGH: rdata <= {18'h00000, offset_count_high};
        `SHS_ADDR_OFS_LOW: rdata <= {18'h00000, offset_count_low};
        `SHS_ADDR_STATUS: rdata <= {16'h0000, 3'h0, state, 1'b0, mode_lat, 1'b0, cfg_ready,
                                    homing_done, homing_busy};
        `SHS_ADDR_INT_STAT: rdata <= {27'h0000000, int_stat};
        `SHS_ADDR_INT_MASK: rdata <= {27'h0000000, int_mask};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule // shs_homing

/* File: test/shs_homing_props.sv */
`timescale 1ns/100ps
// ********
// homing sequencer port checker
// ********
module shs_homing_chk (
  input wire clk, // system clock
  input wire rst, // async reset
  input wire [2:0] homing_mode_setting, // mode strap
  input wire [1:0] output_pin_allocation, // output strap
  input wire [3:0] out_pins_n, // output pins
  input wire positioning_complete, // in position
  input wire mode_switch_req, // host switch request
  input wire ref_pulse_in, // host reference
  input wire mode_switching, // mode change active
  input wire mode_switch_grant, // change granted
  input wire ref_pulse_out, // passed reference
  input wire motor_run, // motor moving
  input wire motor_reverse, // direction
  input wire [11:0] speed_cmd, // speed
  input wire homing_busy, // busy
  input wire homing_done // done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ref_block_a: assert property (homing_busy |-> !ref_pulse_out)
    else $error("reference pulse passed while homing");
  grant_block_a: assert property (homing_busy |-> !mode_switch_grant)
    else $error("mode switch granted while homing");
  ref_pass_a: assert property (!homing_busy && !$past(rst, 2)
    |-> ref_pulse_out == $past(ref_pulse_in, 2))
    else $error("reference pulse not passed when idle");
  grant_pass_a: assert property (!homing_busy && !$past(rst, 2)
    |-> mode_switch_grant == $past(mode_switch_req, 2))
    else $error("mode switch not granted when idle");
  start_gate_a: assert property ($rose(homing_busy) |-> $past(positioning_complete, 3))
    else $error("homing began out of position");
  switch_gate_a: assert property ($rose(homing_busy) |-> !$past(mode_switching, 3))
    else $error("homing began during mode change");
  start_dir_a: assert property ($rose(homing_busy) |-> motor_reverse == homing_mode_setting[0])
    else $error("wrong approach direction");
  done_clear_a: assert property ($rose(homing_busy) |-> !homing_done)
    else $error("done kept at new start");
  done_hold_a: assert property (homing_done |=> homing_done || $rose(homing_busy))
    else $error("done dropped without start");
  stop_state_a: assert property ($rose(homing_done) |-> !motor_run && speed_cmd == 12'h000)
    else $error("motor not stopped at done");
  run_busy_a: assert property (motor_run |-> homing_busy && speed_cmd <= 12'hbb8)
    else $error("motor run outside homing");
  done_pin_a: assert property (homing_done && $past(homing_done)
    |-> out_pins_n == ~(4'h1 << output_pin_allocation))
    else $error("done pin wrong");
  idle_pin_a: assert property (!homing_done && !$past(homing_done) |-> out_pins_n == 4'hf)
    else $error("output pin low without done");
endmodule // shs_homing_chk

bind shs_homing shs_homing_chk chk_u (.clk(clk), .rst(rst),
  .homing_mode_setting(homing_mode_setting), .output_pin_allocation(output_pin_allocation),
  .out_pins_n(out_pins_n), .positioning_complete(positioning_complete),
  .mode_switch_req(mode_switch_req), .ref_pulse_in(ref_pulse_in),
  .mode_switching(mode_switching), .mode_switch_grant(mode_switch_grant),
  .ref_pulse_out(ref_pulse_out), .motor_run(motor_run), .motor_reverse(motor_reverse),
  .speed_cmd(speed_cmd), .homing_busy(homing_busy), .homing_done(homing_done));

/* File: test/shs_far_side.sv */
`timescale 1ns/100ps
// ********
// origin switch and encoder on the shaft
// ********
module shs_far_side #(
  parameter ORG_AT = 20, // run cycles until switch hit
  parameter ORG_LEN = 20 // run cycles on the switch
) (
  input wire clk, // system clock
  input wire rst, // async reset
  input wire motor_run, // motor moving
  output reg origin, // switch level, active high
  output reg index_pulse, // encoder index
  output reg enc_step, // encoder steps
  output reg [15:0] steps // step edges since index
);
  localparam IDX_AT = ORG_AT + ORG_LEN + 20;
  reg [15:0] t;
  // shaft moves only while running, so no edges at standstill
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      t <= 16'h0000;
      origin <= 1'b0;
      index_pulse <= 1'b0;
      enc_step <= 1'b0;
      steps <= 16'h0000;
    end else if (!motor_run) begin
      t <= 16'h0000;
      index_pulse <= 1'b0;
      enc_step <= 1'b0;
    end else begin
      t <= t + 16'h0001;
      origin <= (t >= ORG_AT) && (t < ORG_AT + ORG_LEN);
      index_pulse <= (t >= IDX_AT) && (t < IDX_AT + 3);
      enc_step <= (t >= IDX_AT + 8) && t[1];
      if (t == 16'h0000)
        steps <= 16'h0000;
      else if (t >= IDX_AT + 8 && t[1:0] == 2'b10)
        steps <= steps + 16'h0001;
    end
  end
endmodule // shs_far_side

/* File: test/test_servo_homing_sequencer.sv */
`timescale 1ns/100ps
`include "shs_consts.vh"
// ********
// homing sequencer bench
// ********
module test_servo_homing_sequencer;
  reg clk, rst, wr, rd, pc, msw, msr, refi, start;
  reg [7:0] addr;
  reg [31:0] wdata, seed, nseed, d;
  reg [2:0] hmode;
  reg [1:0] opa;
  reg [1:0] spare;
  reg [11:0] appr, dep;
  reg [13:0] low, high;
  reg [2:0] modes [0:4];
  wire [31:0] rdata;
  wire [3:0] out_pins_n;
  wire [11:0] speed;
  wire [15:0] steps;
  wire grant, ref_out, run, rev, busy, done, irq, origin, idx, step;
  integer err_total, samples_checked, cycles, i, n, e;

  shs_homing dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .homing_mode_setting(hmode), .input_pin_allocation_a(2'h0),
    .input_pin_allocation_b(2'h1), .output_pin_allocation(opa),
    .in_pins({spare, origin, start}), .out_pins_n(out_pins_n), .positioning_complete(pc),
    .mode_switching(msw), .mode_switch_req(msr), .mode_switch_grant(grant),
    .ref_pulse_in(refi), .ref_pulse_out(ref_out), .index_pulse_in(idx),
    .encoder_step_in(step), .motor_run(run), .motor_reverse(rev), .speed_cmd(speed),
    .homing_busy(busy), .homing_done(done), .irq(irq));
  shs_far_side far_u (.clk(clk), .rst(rst), .motor_run(run), .origin(origin),
    .index_pulse(idx), .enc_step(step), .steps(steps));

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function pick(input integer s);
    pick = (s == 0) ? busy : (s == 1) ? origin : done;
  endfunction

  task chk(input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task wreg(input [7:0] a, input [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task wait_on(input integer s, input lvl, input integer lim);
    n = 0;
    while (pick(s) !== lvl && n < lim) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    chk(n < lim, 1);
  endtask
  // start edge while out of position or while the mode changes
  task refused(input integer k);
    pc <= k[0];
    msw <= k[0];
    repeat (6) @(posedge clk);
    start <= 1'b1;
    repeat (12) @(posedge clk);
    #1 chk(busy, 0);
    pc <= 1'b1;
    msw <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk(busy, 0);
    start <= 1'b0;
    rreg(`SHS_ADDR_INT_STAT);
    chk(d, hmode[2] ? 32'h10 : 32'h0);
    wreg(`SHS_ADDR_INT_STAT, 32'h1f);
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // noise on host pins and timeout
  always @(posedge clk) begin
    cycles = cycles + 1;
    nseed = lfsr(nseed);
    refi <= nseed[0];
    msr <= nseed[1];
    spare <= nseed[3:2];
    if (cycles == 60000) begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  // main sequence, one reset per strap setting
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    pc = 1'b1;
    msw = 1'b0;
    start = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    hmode = 3'b100;
    seed = 32'he7d2bf96;
    nseed = 32'he7d2bf96;
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    modes[0] = 3'b100;
    modes[1] = 3'b101;
    modes[2] = 3'b110;
    modes[3] = 3'b111;
    modes[4] = 3'b011;
    for (i = 0; i < 5; i = i + 1) begin
      hmode <= modes[i];
      opa <= i[1:0];
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rreg(`SHS_ADDR_APPROACH);
      chk(d, {20'h0, `SHS_APPROACH_RST});
      rreg(`SHS_ADDR_DEPART);
      chk(d, {20'h0, `SHS_DEPART_RST});
      rreg(8'h1c);
      chk(d, 32'h0);
      wreg(`SHS_ADDR_APPROACH, 32'hfff);
      rreg(`SHS_ADDR_APPROACH);
      chk(d, {20'h0, `SHS_APPROACH_MAX});
      wreg(`SHS_ADDR_OFS_LOW, 32'h3fff);
      rreg(`SHS_ADDR_OFS_LOW);
      chk(d, {18'h0, `SHS_OFS_MAX});
      rreg(`SHS_ADDR_STATUS);
      chk(d[12:0], {5'h01, 1'b0, hmode, 1'b0, 1'b1, 2'b00});
      seed = lfsr(seed);
      appr = 12'd1000 + seed % 2001;
      dep = seed[23:12] % 201;
      low = seed[27:24];
      high = (i == 3);
      e = high * 10000 + low;
      wreg(`SHS_ADDR_APPROACH, {20'h0, appr});
      wreg(`SHS_ADDR_DEPART, {20'h0, dep});
      wreg(`SHS_ADDR_OFS_HIGH, {18'h0, high});
      wreg(`SHS_ADDR_OFS_LOW, {18'h0, low});
      refused(i);
      repeat (6) @(posedge clk);
      start <= 1'b1;
      if (!hmode[2]) begin
        repeat (20) @(posedge clk);
        #1 chk(busy, 0);
      end else begin
        wait_on(0, 1, 10);
        chk(speed, appr);
        chk(rev, hmode[0]);
        wait_on(1, 1, 100);
        wait_on(1, 0, 100);
        repeat (4) @(posedge clk);
        #1 chk(speed, dep);
        chk(rev, hmode[0] ^ !hmode[1]);
        seed = lfsr(seed);
        dep = seed % 201;
        wreg(`SHS_ADDR_DEPART, {20'h0, dep});
        repeat (3) @(posedge clk);
        #1 chk(speed, dep);
        wait_on(2, 1, 45000);
        chk(steps >= e && steps <= e + 1, 1);
        chk({busy, run, speed}, 0);
        rreg(`SHS_ADDR_INT_STAT);
        chk(d & 32'h0f, 32'h0f);
        chk(irq, 0);
        wreg(`SHS_ADDR_INT_MASK, 32'h08);
        @(posedge clk);
        #1 chk(irq, 1);
        wreg(`SHS_ADDR_INT_STAT, 32'h08);
        @(posedge clk);
        #1 chk(irq, 0);
        repeat (10) @(posedge clk);
        #1 chk(done, 1);
        chk(out_pins_n, 4'hf ^ (4'h1 << opa));
      end
      start <= 1'b0;
    end
    print_verdict;
  end
endmodule // test_servo_homing_sequencer
